/* File: include/indirect_access_cfg.svh */
// Offsets, field positions, reset values and select codes of the indirect access port
`ifndef INDIRECT_ACCESS_CFG_SVH
`define INDIRECT_ACCESS_CFG_SVH

// ----------------------------------------------------------------------------
// Directly addressed registers
// ----------------------------------------------------------------------------
`define ACC_CTRL_OFS    8'hB0
`define ACC_OFFSET_OFS  8'hB1
`define ACC_BYTE_OFS    8'hB2

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define CTRL_SEL_MSB    5
`define CTRL_SEL_LSB    2
`define CTRL_STEP_BIT   1
`define CTRL_PREF_BIT   0
`define CTRL_RSVD_ZERO  2'h0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SEL_RST         4'h0
`define OFFSET_RST      8'h00
`define BYTE_RST        8'h00
`define RDATA_RST       8'h00
`define UNMAPPED_RDATA  8'h00

// ----------------------------------------------------------------------------
// Target select codes and block indices
// ----------------------------------------------------------------------------
`define NUM_BLOCKS      5
`define SEL_PATGEN      4'h0
`define SEL_RX0         4'h1
`define SEL_RX1         4'h2
`define SEL_RX_SHARED   4'h5
`define SEL_RX_BOTH     4'h6
`define SEL_CSI         4'h7
`define DUAL_WR_MASK    5'h06

`endif

/* File: include/indirect_access_pkg.sv */
// Types shared by the indirect access port
`include "indirect_access_cfg.svh"

package indirect_access_pkg;

  // Whole state of the access port in one record
  typedef struct packed {
    logic [3:0]               target_block_select;
    logic                     offset_auto_step;
    logic                     prefetch_read_enable;
    logic [7:0]               target_offset;
    logic [7:0]               target_byte;
    logic [7:0]               tgt_offset;
    logic [`NUM_BLOCKS-1:0]   blk_wr;
    logic [`NUM_BLOCKS-1:0]   blk_rd;
    logic [7:0]               rdata;
  } access_state_type;

endpackage

/* File: hdl/indirect_target_mux.sv */
// Target decode and read-data select for the indirect access port
`timescale 1ns/100ps
`default_nettype none
`include "indirect_access_cfg.svh"

module indirect_target_mux #(
  parameter int NUM_BLK = `NUM_BLOCKS
) (
  input  wire logic [3:0]           sel_in,        // Target block select code
  input  wire logic [NUM_BLK*8-1:0] blk_rdata_in,  // Read data of every block
  output logic      [NUM_BLK-1:0]   wr_mask_out,   // Blocks a write reaches
  output logic      [NUM_BLK-1:0]   rd_mask_out,   // Block a read reaches
  output logic      [7:0]           rdata_out      // Selected read data
);

  // ----------------------------------------------------------------------------
  // Per-block decode
  // ----------------------------------------------------------------------------
  localparam logic [4*`NUM_BLOCKS-1:0] BLK_CODES =
    {`SEL_CSI, `SEL_RX_SHARED, `SEL_RX1, `SEL_RX0, `SEL_PATGEN};
  localparam logic [`NUM_BLOCKS-1:0] DUAL_MASK = `DUAL_WR_MASK;

  logic [7:0] chain [NUM_BLK:0];

  assign chain[0] = 8'h00;

  // Reserved codes hit no block, so reads return zero and nothing is strobed
  genvar i;
  generate
    for (i = 0; i < NUM_BLK; i++) begin : g_blk
      assign rd_mask_out[i] = (sel_in == BLK_CODES[4*i +: 4]);  // [R01]
      // Dual code writes both receive ports in the same cycle
      assign wr_mask_out[i] = rd_mask_out[i] ||
                              ((sel_in == `SEL_RX_BOTH) && DUAL_MASK[i]);  // [R02]
      assign chain[i+1] = chain[i] |
                          (rd_mask_out[i] ? blk_rdata_in[8*i +: 8] : 8'h00);
    end
  endgenerate

  assign rdata_out = chain[NUM_BLK];

endmodule
`default_nettype wire

/* File: hdl/indirect_access_port.sv */
// Indirect register access port: control, offset and data registers
//
// Operation
// R01 - Four-bit select picks the internal target block
// R02 - Select 0110 writes both receive ports together
// R03 - Auto-step adds one after each access
// R04 - Offset write strobes read when prefetch enabled
// R05 - Data read with step and prefetch strobes again
// R06 - Host sets prefetch only for prefetching blocks
// R07 - Eight-bit offset targets every indirect access
// R08 - Data write writes byte at current offset
// R09 - Data read returns selected block's register
// R10 - Control top bits zero; fields reset zero
// R11 - Host uses byte accesses on control bus
`timescale 1ns/100ps
`default_nettype none
`include "indirect_access_cfg.svh"

module indirect_access_port
  import indirect_access_pkg::*;
#(
  parameter int NUM_BLK = `NUM_BLOCKS
) (
  input  wire logic                 ref_clk_in,     // Register clock
  input  wire logic                 rst_n_in,       // Async reset, active low
  input  wire logic [7:0]           reg_addr_in,    // Byte address from bus slave
  input  wire logic [7:0]           reg_wdata_in,   // Write byte
  input  wire logic                 reg_wr_in,      // Write strobe, one cycle
  input  wire logic                 reg_rd_in,      // Read strobe, one cycle
  output logic      [7:0]           reg_rdata_out,  // Read byte, one cycle late
  output logic      [7:0]           tgt_offset_out, // Offset inside target block
  output logic      [7:0]           tgt_wdata_out,  // Byte for target write
  output logic      [NUM_BLK-1:0]   blk_wr_out,     // Per-block write strobe
  output logic      [NUM_BLK-1:0]   blk_rd_out,     // Per-block read strobe
  input  wire logic [NUM_BLK*8-1:0] blk_rdata_in    // Per-block read data
);

  // ----------------------------------------------------------------------------
  // State and decode
  // ----------------------------------------------------------------------------
  access_state_type q;
  access_state_type d;

  logic [NUM_BLK-1:0] wr_mask;
  logic [NUM_BLK-1:0] rd_mask;
  logic [7:0]         blk_rdata;
  logic               wr_ctrl;
  logic               wr_off;
  logic               wr_byte;
  logic               rd_byte;

  // Byte accesses arrive from the control bus slave, one per strobe
  assign wr_ctrl = reg_wr_in && (reg_addr_in == `ACC_CTRL_OFS);    // [R11]
  assign wr_off  = reg_wr_in && (reg_addr_in == `ACC_OFFSET_OFS);  // [R11]
  assign wr_byte = reg_wr_in && (reg_addr_in == `ACC_BYTE_OFS);    // [R11]
  assign rd_byte = reg_rd_in && !reg_wr_in &&
                   (reg_addr_in == `ACC_BYTE_OFS);                 // [R11]

  indirect_target_mux #(
    .NUM_BLK (NUM_BLK)
  ) u_mux (
    .sel_in       (q.target_block_select),
    .blk_rdata_in (blk_rdata_in),
    .wr_mask_out  (wr_mask),
    .rd_mask_out  (rd_mask),
    .rdata_out    (blk_rdata)
  );

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  // Strobes last one cycle; the target offset normally follows the stored one
  always_comb begin
    d            = q;
    d.blk_wr     = '0;
    d.blk_rd     = '0;
    d.tgt_offset = q.target_offset;  // [R07]
    if (wr_ctrl) begin
      d.target_block_select  = reg_wdata_in[`CTRL_SEL_MSB:`CTRL_SEL_LSB];  // [R01]
      d.offset_auto_step     = reg_wdata_in[`CTRL_STEP_BIT];
      d.prefetch_read_enable = reg_wdata_in[`CTRL_PREF_BIT];
    end
    if (wr_off) begin
      d.target_offset = reg_wdata_in;  // [R07]
      d.tgt_offset    = reg_wdata_in;
      // Prefetch lets slow blocks stage data before the host reads it
      if (q.prefetch_read_enable) begin
        d.blk_rd = rd_mask;  // [R04]
      end
    end else if (wr_byte) begin
      d.target_byte = reg_wdata_in;
      d.blk_wr      = wr_mask;          // [R08]
      // Strobe goes out at the old offset while the stored one steps
      d.tgt_offset  = q.target_offset;  // [R08]
      if (q.offset_auto_step) begin
        d.target_offset = q.target_offset + 8'h01;  // [R03]
      end
    end else if (rd_byte) begin
      if (q.offset_auto_step) begin
        d.target_offset = q.target_offset + 8'h01;  // [R03]
        d.tgt_offset    = q.target_offset + 8'h01;
        if (q.prefetch_read_enable) begin
          d.blk_rd = rd_mask;  // [R05]
        end
      end
    end
    // Read data is captured here, so it reflects the offset before any step
    if (reg_rd_in && !reg_wr_in) begin
      case (reg_addr_in)
        `ACC_CTRL_OFS: begin
          d.rdata = {`CTRL_RSVD_ZERO, q.target_block_select,
                     q.offset_auto_step, q.prefetch_read_enable};  // [R10]
        end
        `ACC_OFFSET_OFS: begin
          d.rdata = q.target_offset;
        end
        `ACC_BYTE_OFS: begin
          d.rdata = blk_rdata;  // [R09]
        end
        default: begin
          d.rdata = `UNMAPPED_RDATA;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q.target_block_select  <= `SEL_RST;  // [R10]
      q.offset_auto_step     <= 1'b0;      // [R10]
      q.prefetch_read_enable <= 1'b0;      // [R10]
      q.target_offset        <= `OFFSET_RST;
      q.target_byte          <= `BYTE_RST;
      q.tgt_offset           <= `OFFSET_RST;
      q.blk_wr               <= '0;
      q.blk_rd               <= '0;
      q.rdata                <= `RDATA_RST;
    end else begin
      q <= d;
    end
  end

  // Every output is a flop of the state record
  assign reg_rdata_out  = q.rdata;
  assign tgt_offset_out = q.tgt_offset;
  assign tgt_wdata_out  = q.target_byte;
  assign blk_wr_out     = q.blk_wr;
  assign blk_rd_out     = q.blk_rd;

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_off_write_pref;
    wr_off && q.prefetch_read_enable;
  endsequence

  sequence s_byte_read_step_pref;
    rd_byte && !wr_off && !wr_byte &&
    q.offset_auto_step && q.prefetch_read_enable;
  endsequence

  // A data write in the very next cycle may legally strobe again
  property p_sel_rx0;
    wr_byte && (q.target_block_select == `SEL_RX0)
      |=> (blk_wr_out == 5'h02) ##1 ($past(wr_byte) || (blk_wr_out == 5'h00));
  endproperty
  a_sel_rx0: assert property (p_sel_rx0)  // [R01]
    else $error("receive port zero select did not strobe one block");

  property p_dual_write;
    wr_byte && (q.target_block_select == `SEL_RX_BOTH) |=> blk_wr_out == 5'h06;
  endproperty
  a_dual_write: assert property (p_dual_write)  // [R02]
    else $error("dual select did not write both receive ports");

  property p_auto_step;
    (wr_byte || rd_byte) && !wr_off && q.offset_auto_step
      |=> q.target_offset == $past(q.target_offset) + 8'h01;
  endproperty
  a_auto_step: assert property (p_auto_step)  // [R03]
    else $error("offset did not step by one");

  property p_prefetch_offset;
    s_off_write_pref
      |=> (blk_rd_out == $past(rd_mask)) && (tgt_offset_out == $past(reg_wdata_in));
  endproperty
  a_prefetch_offset: assert property (p_prefetch_offset)  // [R04]
    else $error("offset write gave no prefetch strobe at new offset");

  property p_prefetch_data;
    s_byte_read_step_pref
      |=> (blk_rd_out == $past(rd_mask)) &&
          (tgt_offset_out == $past(q.target_offset) + 8'h01);
  endproperty
  a_prefetch_data: assert property (p_prefetch_data)  // [R05]
    else $error("data read gave no prefetch strobe at next offset");

  property p_offset_hold;
    !wr_off && !wr_byte && !rd_byte |=> $stable(q.target_offset);
  endproperty
  a_offset_hold: assert property (p_offset_hold)  // [R07]
    else $error("offset changed without an access");

  property p_write_byte;
    wr_byte |=> (tgt_wdata_out == $past(reg_wdata_in)) &&
                (tgt_offset_out == $past(q.target_offset));
  endproperty
  a_write_byte: assert property (p_write_byte)  // [R08]
    else $error("write strobe carried wrong byte or offset");

  property p_read_back;
    rd_byte |=> reg_rdata_out == $past(blk_rdata);
  endproperty
  a_read_back: assert property (p_read_back)  // [R09]
    else $error("data read did not return the block contents");

  property p_ctrl_reserved;
    reg_rd_in && !reg_wr_in && (reg_addr_in == `ACC_CTRL_OFS)
      |=> (reg_rdata_out[7:6] == 2'h0) &&
          (reg_rdata_out[5:2] == $past(q.target_block_select)) &&
          (reg_rdata_out[1] == $past(q.offset_auto_step)) &&
          (reg_rdata_out[0] == $past(q.prefetch_read_enable));
  endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved)  // [R10]
    else $error("control reserved bits read nonzero");

endmodule
`default_nettype wire

/* File: verification/indirect_block_model.sv */
// Behavioural model of the internal register blocks behind the access port
`timescale 1ns/100ps
`default_nettype none

module indirect_block_model #(
  parameter int NUM_BLK = 5
) (
  input  wire logic                 ref_clk_in,     // Register clock
  input  wire logic                 rst_n_in,       // Async reset, active low
  input  wire logic [7:0]           tgt_offset_in,  // Offset inside block
  input  wire logic [7:0]           tgt_wdata_in,   // Byte to write
  input  wire logic [NUM_BLK-1:0]   blk_wr_in,      // Per-block write strobe
  output logic      [NUM_BLK*8-1:0] blk_rdata_out   // Per-block read data
);
  logic [7:0] mem [NUM_BLK][256];

  // Reset loads a pattern unique per block and offset so misrouted reads show
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    for (int b = 0; b < NUM_BLK; b++) begin
      for (int o = 0; o < 256; o++) begin
        if (!rst_n_in) begin
          mem[b][o] <= {b[2:0], 5'h00} ^ o[7:0];
        end else if (blk_wr_in[b] && o[7:0] == tgt_offset_in) begin
          mem[b][o] <= tgt_wdata_in;
        end
      end
    end
  end

  // Read data follows the offset at once, as the port samples it directly
  always_comb begin
    for (int b = 0; b < NUM_BLK; b++) begin
      blk_rdata_out[b*8 +: 8] = mem[b][tgt_offset_in];
    end
  end
endmodule
`default_nettype wire

/* File: verification/test_indirect_access_port.sv */
// Self-checking testbench of the indirect register access port
`timescale 1ns/100ps
`default_nettype none
`include "indirect_access_cfg.svh"

module test_indirect_access_port;
  import indirect_access_pkg::*;
  localparam int NB = `NUM_BLOCKS;
  logic            ref_clk_in, rst_n_in, reg_wr_in, reg_rd_in;
  logic [7:0]      reg_addr_in, reg_wdata_in, reg_rdata_out, tgt_offset_out, tgt_wdata_out, rv;
  logic [NB-1:0]   blk_wr_out, blk_rd_out;
  logic [NB*8-1:0] blk_rdata_in;
  int              miscompares, total_checks, rd_cnt[NB], wr_cnt[NB];
  logic [3:0]      sel_tab[NB] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h7};

  indirect_access_port #(.NUM_BLK(NB)) i_dut (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .tgt_offset_out(tgt_offset_out),
    .tgt_wdata_out(tgt_wdata_out), .blk_wr_out(blk_wr_out), .blk_rd_out(blk_rd_out),
    .blk_rdata_in(blk_rdata_in));
  indirect_block_model #(.NUM_BLK(NB)) i_blocks (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .tgt_offset_in(tgt_offset_out),
    .tgt_wdata_in(tgt_wdata_out), .blk_wr_in(blk_wr_out), .blk_rdata_out(blk_rdata_in));

  // -------------------------------------------------------------------------
  // Clock, strobe counters and helpers
  // -------------------------------------------------------------------------
  initial begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end

  // Strobes last one cycle, so counting them is the only way to see extras
  always @(posedge ref_clk_in) begin
    for (int i = 0; i < NB; i++) begin
      rd_cnt[i] += int'(blk_rd_out[i]);
      wr_cnt[i] += int'(blk_wr_out[i]);
    end
  end

  function automatic logic [7:0] pat(input int b, input logic [7:0] o);
    return {b[2:0], 5'h00} ^ o;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(negedge ref_clk_in);
    reg_wr_in = 1'b0;
  endtask

  // Read byte is registered, so it is settled at the next falling edge
  task automatic rd(input logic [7:0] a);
    @(negedge ref_clk_in);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(negedge ref_clk_in);
    reg_rd_in = 1'b0;
    rv = reg_rdata_out;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    rd(a);
    chk(rv, exp, what);
  endtask

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk_in);
    miscompares++;
    finish_test();
  end

  // -------------------------------------------------------------------------
  // Test sequence
  // -------------------------------------------------------------------------
  initial begin
    rst_n_in = 1'b0;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 8'h00;
    miscompares = 0;
    total_checks = 0;
    foreach (rd_cnt[i]) rd_cnt[i] = 0;
    foreach (wr_cnt[i]) wr_cnt[i] = 0;
    repeat (10) @(negedge ref_clk_in);
    rst_n_in = 1'b1;
    chk_rd(`ACC_CTRL_OFS, 8'h00, "control reset");
    wr(`ACC_CTRL_OFS, 8'hFF);
    chk_rd(`ACC_CTRL_OFS, 8'h3F, "control top bits");
    chk_rd(8'hB3, `UNMAPPED_RDATA, "unmapped read");
    $display("test reset done");
    // Every documented block: write with step, check offset, read back
    for (int k = 0; k < NB; k++) begin
      wr(`ACC_CTRL_OFS, {2'b00, sel_tab[k], 2'b10});
      wr(`ACC_OFFSET_OFS, 8'h10);
      wr(`ACC_BYTE_OFS, 8'hA0 + 8'(k));
      chk_rd(`ACC_OFFSET_OFS, 8'h11, "step after write");
      wr(`ACC_OFFSET_OFS, 8'h10);
      chk_rd(`ACC_BYTE_OFS, 8'hA0 + 8'(k), "block read back");
    end
    chk(tgt_wdata_out, 8'hA4, "write byte held");
    for (int k = 0; k < NB; k++) chk(8'(wr_cnt[k]), 8'h01, "one write each");
    for (int k = 0; k < NB; k++) chk(8'(rd_cnt[k]), 8'h00, "no prefetch");
    $display("test select done");
    // Dual write reaches both receive ports, nothing else
    wr(`ACC_CTRL_OFS, 8'h18);
    wr(`ACC_OFFSET_OFS, 8'h30);
    wr(`ACC_BYTE_OFS, 8'h5C);
    chk_rd(`ACC_BYTE_OFS, 8'h00, "dual select read");
    wr(`ACC_CTRL_OFS, 8'h04);
    chk_rd(`ACC_BYTE_OFS, 8'h5C, "port zero copy");
    wr(`ACC_CTRL_OFS, 8'h08);
    chk_rd(`ACC_BYTE_OFS, 8'h5C, "port one copy");
    chk(8'(wr_cnt[0] + wr_cnt[3] + wr_cnt[4]), 8'h03, "dual stray");
    $display("test dual done");
    // Prefetching block: strobes on offset write and each stepped data read
    wr(`ACC_CTRL_OFS, 8'h17);
    wr(`ACC_OFFSET_OFS, 8'h40);
    // The strobe is counted at the edge after it rises, so let one cycle pass
    @(negedge ref_clk_in);
    chk(8'(rd_cnt[3]), 8'h01, "offset strobe");
    chk_rd(`ACC_BYTE_OFS, pat(3, 8'h40), "prefetch read");
    chk_rd(`ACC_BYTE_OFS, pat(3, 8'h41), "stepped read");
    chk_rd(`ACC_OFFSET_OFS, 8'h42, "offset after reads");
    wr(`ACC_OFFSET_OFS, 8'hFF);
    chk_rd(`ACC_BYTE_OFS, pat(3, 8'hFF), "top offset read");
    chk_rd(`ACC_OFFSET_OFS, 8'h00, "offset wrap");
    chk(8'(rd_cnt[3]), 8'h05, "read strobes");
    chk(8'(rd_cnt[0] + rd_cnt[1] + rd_cnt[2] + rd_cnt[4]), 8'h00, "stray strobe");
    $display("test prefetch done");
    // No step, then step without prefetch: never a strobe
    wr(`ACC_CTRL_OFS, 8'h14);
    wr(`ACC_OFFSET_OFS, 8'h50);
    chk_rd(`ACC_BYTE_OFS, pat(3, 8'h50), "plain read");
    chk_rd(`ACC_OFFSET_OFS, 8'h50, "offset held");
    wr(`ACC_CTRL_OFS, 8'h16);
    chk_rd(`ACC_BYTE_OFS, pat(3, 8'h50), "step read");
    chk_rd(`ACC_OFFSET_OFS, 8'h51, "offset stepped");
    chk(8'(rd_cnt[3]), 8'h05, "strobe count held");
    // Reserved codes reach no block
    wr(`ACC_CTRL_OFS, 8'h0C);
    wr(`ACC_BYTE_OFS, 8'h77);
    chk_rd(`ACC_BYTE_OFS, 8'h00, "reserved read");
    wr(`ACC_CTRL_OFS, 8'h20);
    chk_rd(`ACC_BYTE_OFS, 8'h00, "high reserved read");
    chk(8'(wr_cnt[0] + wr_cnt[1] + wr_cnt[2] + wr_cnt[3] + wr_cnt[4]), 8'h07,
        "reserved write");
    $display("test reserved done");
    // Mid-run reset must clear the fields and the offset again
    @(negedge ref_clk_in);
    rst_n_in = 1'b0;
    repeat (2) @(negedge ref_clk_in);
    rst_n_in = 1'b1;
    chk_rd(`ACC_CTRL_OFS, 8'h00, "control after reset");
    chk_rd(`ACC_OFFSET_OFS, `OFFSET_RST, "offset after reset");
    $display("test mid reset done");
    finish_test();
  end
endmodule
`default_nettype wire
